// *** hdl/dsm_pkg.sv ***
// dsm_pkg: register map, field layout and source codes of the carrier-select stage
// assumes a 32-bit classic Wishbone slave with word-aligned registers
package dsm_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [3:0] DSM_ADDR_CON  = 4'h0;
  localparam logic [3:0] DSM_ADDR_SRC  = 4'h4;
  localparam logic [3:0] DSM_ADDR_CARH = 4'h8;
  localparam logic [3:0] DSM_ADDR_CARL = 4'hC;

  // ----------------------------------------
  // carrier control fields
  // ----------------------------------------
  localparam int DSM_CAR_SEL_LSB = 0;
  localparam int DSM_CAR_SYNC    = 5;
  localparam int DSM_CAR_INV     = 6;
  localparam int DSM_CAR_PDIS    = 7;
  localparam logic [7:0] DSM_CAR_WMASK = 8'hEF;

  // ----------------------------------------
  // modulation control fields
  // ----------------------------------------
  localparam int DSM_CON_EN    = 7;
  localparam int DSM_CON_OE    = 6;
  localparam int DSM_CON_SLEW  = 5;
  localparam int DSM_CON_OINV  = 4;
  localparam int DSM_CON_OUT   = 3;
  localparam int DSM_CON_BIT   = 0;
  localparam logic [7:0] DSM_CON_WMASK = 8'hF1;
  localparam logic [7:0] DSM_CON_RESET = 8'h20;
  localparam logic [7:0] DSM_SRC_WMASK = 8'h8F;

  // undefined power-on value, chosen as zero
  localparam logic [7:0] DSM_CAR_RESET = 8'h00;
  localparam logic [7:0] DSM_SRC_RESET = 8'h00;

  // ----------------------------------------
  // carrier source codes
  // ----------------------------------------
  localparam logic [3:0] DSM_SRC_LOW  = 4'h0;
  localparam logic [3:0] DSM_SRC_PIN1 = 4'h1;
  localparam logic [3:0] DSM_SRC_PIN2 = 4'h2;
  localparam logic [3:0] DSM_SRC_REFC = 4'h3;
  localparam logic [3:0] DSM_SRC_PWM1 = 4'h4;

  // modulation source codes
  localparam logic [3:0] DSM_MS_BIT   = 4'h0;
  localparam logic [3:0] DSM_MS_PIN   = 4'h1;
  localparam logic [3:0] DSM_MS_PWM1  = 4'h2;

  typedef enum logic [0:0] {DSM_USE_LOW, DSM_USE_HIGH} dsm_sel_t;

endpackage

// *** hdl/dsm_carrier_path.sv ***
// dsm_carrier_path: one carrier path: source select, inversion, falling-edge detect
// assumes every source is already synchronised to CLK
`timescale 1ns/1ps
module dsm_carrier_path
  import dsm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [3:0] sel,
  input  wire logic       invert,
  input  wire logic [7:0] sources,
  output logic            carrier,
  output logic            fall,
  output logic [7:0]      pin_kill
);

  // ----------------------------------------
  // selection
  // ----------------------------------------
  wire logic       sel_valid;
  wire logic       raw;
  logic            prev;

  assign sel_valid = ~sel[3];
  assign raw       = sel_valid ? sources[sel[2:0]] : 1'b0;
  assign carrier   = raw ^ invert;
  assign fall      = prev & ~carrier;

  // one-hot of the peripheral chosen, for pin disable
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_kill
      assign pin_kill[gi] = sel_valid && (sel[2:0] == 3'(gi));
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prev <= 1'b0;
    else
      prev <= carrier;
  end

  property p_inv_pass;
    @(posedge clk) disable iff (!resetn)
    sel == DSM_SRC_LOW |-> carrier == invert;
  endproperty
  a_inv_pass: assert property (p_inv_pass) else $error("constant-low source wrong");

endmodule // dsm_carrier_path

// *** hdl/dsm_carrier_select.sv ***
// dsm_carrier_select: carrier-select and modulator mixing stage with Wishbone registers
// assumes pins are asynchronous; PWM and reference clock share CLK
`timescale 1ns/1ps
module dsm_carrier_select
  import dsm_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        POR_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        CARRIER_PIN_ONE,
  input  wire logic        CARRIER_PIN_TWO,
  input  wire logic        MOD_PIN,
  input  wire logic        REFERENCE_CLOCK_OUTPUT,
  input  wire logic [3:0]  PWM_CHANNEL,
  output logic             MODULATED_OUTPUT_VALUE,
  output logic             MODULATOR_PIN_OUTPUT_ENABLE,
  output logic             OUTPUT_SLEW_LIMIT,
  output logic [7:0]       CARRIER_PIN_DISABLE,
  output logic             MOD_SOURCE_PIN_DISABLE
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end
    else
    begin
      pin_s1 <= {MOD_PIN, CARRIER_PIN_TWO, CARRIER_PIN_ONE};
      pin_s2 <= pin_s1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] modulation_control;
  logic [7:0] modulation_source_control;
  logic [7:0] high_carrier_control;
  logic [7:0] low_carrier_control;

  wire logic       bus_req;
  wire logic       bus_wr;
  wire logic       hit_con;
  wire logic       hit_src;
  wire logic       hit_carh;
  wire logic       hit_carl;
  wire logic       out_now;
  wire logic [7:0] con_rd;
  wire logic [7:0] rd_byte;

  assign bus_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign bus_wr   = bus_req & WB_WE_I & WB_SEL_I[0];
  assign hit_con  = WB_ADR_I == DSM_ADDR_CON;
  assign hit_src  = WB_ADR_I == DSM_ADDR_SRC;
  assign hit_carh = WB_ADR_I == DSM_ADDR_CARH;
  assign hit_carl = WB_ADR_I == DSM_ADDR_CARL;
  assign con_rd   = (modulation_control & DSM_CON_WMASK) | ({7'h00, out_now} << DSM_CON_OUT);
  // unmapped addresses still ack and read zero
  assign rd_byte  = hit_con  ? con_rd :
                    hit_src  ? modulation_source_control :
                    hit_carh ? high_carrier_control :
                    hit_carl ? low_carrier_control : 8'h00;

  // carrier registers only lose their value on power-on, not on RESETN
  always_ff @(posedge CLK or negedge POR_N)
  begin
    if (!POR_N)
    begin
      high_carrier_control      <= DSM_CAR_RESET;
      low_carrier_control       <= DSM_CAR_RESET;
      modulation_source_control <= DSM_SRC_RESET;
    end
    else if (bus_wr && hit_carh)
      high_carrier_control <= WB_DAT_I[7:0] & DSM_CAR_WMASK;
    else if (bus_wr && hit_carl)
      low_carrier_control <= WB_DAT_I[7:0] & DSM_CAR_WMASK;
    else if (bus_wr && hit_src)
      modulation_source_control <= WB_DAT_I[7:0] & DSM_SRC_WMASK;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      modulation_control <= DSM_CON_RESET;
      WB_ACK_O           <= 1'b0;
      WB_DAT_O           <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= {24'h00_0000, rd_byte};
      if (bus_wr && hit_con)
        modulation_control <= WB_DAT_I[7:0] & DSM_CON_WMASK;
    end
  end

  // ----------------------------------------
  // carrier paths
  // ----------------------------------------
  wire logic [7:0] sources;
  wire logic       car_high;
  wire logic       car_low;
  wire logic       fall_high;
  wire logic       fall_low;
  wire logic [7:0] kill_high;
  wire logic [7:0] kill_low;

  assign sources = {PWM_CHANNEL, REFERENCE_CLOCK_OUTPUT, pin_s2[1], pin_s2[0], 1'b0};

  dsm_carrier_path u_high (
    .clk      (CLK),
    .resetn   (RESETN),
    .sel      (high_carrier_control[3:0]),
    .invert   (high_carrier_control[DSM_CAR_INV]),
    .sources  (sources),
    .carrier  (car_high),
    .fall     (fall_high),
    .pin_kill (kill_high)
  );

  dsm_carrier_path u_low (
    .clk      (CLK),
    .resetn   (RESETN),
    .sel      (low_carrier_control[3:0]),
    .invert   (low_carrier_control[DSM_CAR_INV]),
    .sources  (sources),
    .carrier  (car_low),
    .fall     (fall_low),
    .pin_kill (kill_low)
  );

  // ----------------------------------------
  // modulation source and mixing
  // ----------------------------------------
  wire logic [3:0] ms_sel;
  wire logic       mod_sig;
  wire logic       enable;
  wire dsm_sel_t   want;
  wire logic       may_switch;
  dsm_sel_t        use_sel;
  wire dsm_sel_t   next_use_sel;
  wire logic       mixed;

  assign ms_sel  = modulation_source_control[3:0];
  assign mod_sig = (ms_sel == DSM_MS_BIT) ? modulation_control[DSM_CON_BIT] :
                   (ms_sel == DSM_MS_PIN) ? pin_s2[2] :
                   (ms_sel >= DSM_MS_PWM1 && ms_sel < 4'h6) ?
                     PWM_CHANNEL[2'(ms_sel - DSM_MS_PWM1)] : 1'b0;
  assign enable  = modulation_control[DSM_CON_EN];
  assign want    = mod_sig ? DSM_USE_HIGH : DSM_USE_LOW;
  // spurs traded for latency: unsynced paths switch at once
  assign may_switch = (use_sel == DSM_USE_HIGH) ?
                      (~high_carrier_control[DSM_CAR_SYNC] | fall_high) :
                      (~low_carrier_control[DSM_CAR_SYNC] | fall_low);
  assign next_use_sel = (want != use_sel && may_switch) ? want : use_sel;
  assign mixed   = (use_sel == DSM_USE_HIGH) ? car_high : car_low;
  assign out_now = MODULATED_OUTPUT_VALUE;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      use_sel                     <= DSM_USE_LOW;
      MODULATED_OUTPUT_VALUE      <= 1'b0;
      MODULATOR_PIN_OUTPUT_ENABLE <= 1'b0;
      OUTPUT_SLEW_LIMIT           <= 1'b1;
      CARRIER_PIN_DISABLE         <= 8'h00;
      MOD_SOURCE_PIN_DISABLE      <= 1'b0;
    end
    else
    begin
      use_sel                <= enable ? next_use_sel : want;
      MODULATED_OUTPUT_VALUE <= enable & (mixed ^ modulation_control[DSM_CON_OINV]);
      MODULATOR_PIN_OUTPUT_ENABLE <= enable & modulation_control[DSM_CON_OE];
      OUTPUT_SLEW_LIMIT      <= modulation_control[DSM_CON_SLEW];
      CARRIER_PIN_DISABLE    <= ({8{high_carrier_control[DSM_CAR_PDIS]}} & kill_high)
                              | ({8{low_carrier_control[DSM_CAR_PDIS]}} & kill_low);
      MOD_SOURCE_PIN_DISABLE <= modulation_source_control[7];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_high_sync;
    @(posedge CLK) disable iff (!RESETN)
    (enable && use_sel == DSM_USE_HIGH && high_carrier_control[DSM_CAR_SYNC] && !fall_high)
      |=> use_sel == DSM_USE_HIGH;
  endproperty
  a_high_sync: assert property (p_high_sync) else $error("high sync switched early");

  property p_low_sync;
    @(posedge CLK) disable iff (!RESETN)
    (enable && use_sel == DSM_USE_LOW && low_carrier_control[DSM_CAR_SYNC] && !fall_low)
      |=> use_sel == DSM_USE_LOW;
  endproperty
  a_low_sync: assert property (p_low_sync) else $error("low sync switched early");

  // a held switch must go through on the falling edge itself
  sequence s_high_fall;
    use_sel == DSM_USE_HIGH && high_carrier_control[DSM_CAR_SYNC] && fall_high;
  endsequence
  property p_high_release;
    @(posedge CLK) disable iff (!RESETN)
    enable && want == DSM_USE_LOW ##0 s_high_fall |=> use_sel == DSM_USE_LOW;
  endproperty
  a_high_release: assert property (p_high_release) else $error("high sync not released");

  sequence s_low_fall;
    use_sel == DSM_USE_LOW && low_carrier_control[DSM_CAR_SYNC] && fall_low;
  endsequence
  property p_low_release;
    @(posedge CLK) disable iff (!RESETN)
    enable && want == DSM_USE_HIGH ##0 s_low_fall |=> use_sel == DSM_USE_HIGH;
  endproperty
  a_low_release: assert property (p_low_release) else $error("low sync not released");

  property p_idle_follow;
    @(posedge CLK) disable iff (!RESETN)
    !enable |=> use_sel == $past(want);
  endproperty
  a_idle_follow: assert property (p_idle_follow) else $error("idle selection stale");

  property p_oe_off;
    @(posedge CLK) disable iff (!RESETN)
    !enable |=> !MODULATOR_PIN_OUTPUT_ENABLE;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin enable while off");

  property p_nosync;
    @(posedge CLK) disable iff (!RESETN)
    (enable && !high_carrier_control[DSM_CAR_SYNC] && !low_carrier_control[DSM_CAR_SYNC]
     && $stable(mod_sig)) |=> use_sel == $past(want);
  endproperty
  a_nosync: assert property (p_nosync) else $error("unsynced switch delayed");

  property p_disabled;
    @(posedge CLK) disable iff (!RESETN)
    !enable |=> !MODULATED_OUTPUT_VALUE;
  endproperty
  a_disabled: assert property (p_disabled) else $error("output while disabled");

  property p_outinv;
    @(posedge CLK) disable iff (!RESETN)
    enable |=> MODULATED_OUTPUT_VALUE == ($past(mixed) ^ $past(modulation_control[DSM_CON_OINV]));
  endproperty
  a_outinv: assert property (p_outinv) else $error("output polarity wrong");

  property p_bit4;
    @(posedge CLK) disable iff (!RESETN)
    !high_carrier_control[4] && !low_carrier_control[4];
  endproperty
  a_bit4: assert property (p_bit4) else $error("carrier bit 4 set");

  property p_reserved;
    @(posedge CLK) disable iff (!RESETN)
    high_carrier_control[3] |-> car_high == high_carrier_control[DSM_CAR_INV];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not low");

  sequence s_hkill;
    high_carrier_control[DSM_CAR_PDIS] && !high_carrier_control[3];
  endsequence
  property p_hkill;
    @(posedge CLK) disable iff (!RESETN)
    s_hkill |=> CARRIER_PIN_DISABLE[$past(high_carrier_control[2:0])];
  endproperty
  a_hkill: assert property (p_hkill) else $error("high pin not disabled");

  property p_lkill;
    @(posedge CLK) disable iff (!RESETN)
    (low_carrier_control[DSM_CAR_PDIS] && !low_carrier_control[3])
      |=> CARRIER_PIN_DISABLE[$past(low_carrier_control[2:0])];
  endproperty
  a_lkill: assert property (p_lkill) else $error("low pin not disabled");

endmodule // dsm_carrier_select

// *** verification/dsm_source_model.sv ***
// dsm_source_model: pin and on-chip carrier and modulation sources seen by the carrier-select stage
// assumes one clock; every source changes just after a rising edge
`timescale 1ns/1ps
module dsm_source_model
(
  input  wire logic       clk,
  input  wire logic       resetn,
  output logic            pin_one,
  output logic            pin_two,
  output logic            mod_pin,
  output logic            ref_clk,
  output logic [3:0]      pwm
);
  logic [7:0] cnt;

  // ----------------------------------------
  // free-running phase counter
  // ----------------------------------------
  // mixed periods and duties, all from one counter, so edges of different sources often fall on the same cycle
  always @(posedge clk or negedge resetn)
    if (!resetn)
      cnt <= 8'h00;
    else
      cnt <= cnt + 8'h01;

  assign ref_clk = cnt[1];
  assign pwm     = {cnt[4] & cnt[3], cnt[2] | cnt[5], cnt[3], cnt[1] & cnt[0]};
  assign pin_one = cnt[5] ^ cnt[2];
  assign pin_two = cnt[6] | cnt[0];
  assign mod_pin = cnt[4] ^ cnt[7];
endmodule // dsm_source_model

// *** verification/tb_dsm_carrier_select.sv ***
// tb_dsm_carrier_select: self-checking bench with a cycle model of the carrier-select stage
// assumes dsm_pkg, the design and dsm_source_model are compiled first
`timescale 1ns/1ps
module tb_dsm_carrier_select
  import dsm_pkg::*;
;
  logic        clk = 1'b0, resetn = 1'b0, por_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, dat_o;
  logic        ack, out, oe, slew, msd, p1, p2, mp, refc;
  logic [3:0]  pwm;
  logic [7:0]  pd, m_con, m_src, m_h, m_l, e_pd, v;
  logic [5:0]  sy;
  logic        cur, nxt, hp, lp, h, l, md, e_out, e_oe, e_slew, e_msd, m_ack, run = 1'b0;
  int          error_cnt = 0, samples_checked = 0;

  always #4 clk = ~clk;

  dsm_carrier_select dsm_carrier_select_inst (.CLK(clk), .RESETN(resetn), .POR_N(por_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CARRIER_PIN_ONE(p1),
    .CARRIER_PIN_TWO(p2), .MOD_PIN(mp), .REFERENCE_CLOCK_OUTPUT(refc), .PWM_CHANNEL(pwm),
    .MODULATED_OUTPUT_VALUE(out), .MODULATOR_PIN_OUTPUT_ENABLE(oe),
    .OUTPUT_SLEW_LIMIT(slew), .CARRIER_PIN_DISABLE(pd), .MOD_SOURCE_PIN_DISABLE(msd));

  dsm_source_model dsm_source_model_inst (.clk(clk), .resetn(resetn), .pin_one(p1),
    .pin_two(p2), .mod_pin(mp), .ref_clk(refc), .pwm(pwm));

  // ----------------------------------------
  // reference model, one step per edge
  // ----------------------------------------
  // reads inputs before the edge's updates land, like the design's flops
  always @(posedge clk or negedge resetn or negedge por_n)
  begin
    if (!por_n)
    begin
      m_h = 8'h00;
      m_l = 8'h00;
      m_src = 8'h00;
    end
    if (!resetn || !por_n)
    begin
      m_con = 8'h20;
      {cur, hp, lp, e_out, e_oe, e_slew, sy, e_pd} = {5'h00, 1'b1, 6'h00, 8'h00};
      e_msd = 1'b0;
      m_ack = 1'b0;
    end
    else
    begin
      v = {pwm, refc, sy[3], sy[1], 1'b0};
      h = (m_h[3] ? 1'b0 : v[m_h[2:0]]) ^ m_h[6];
      l = (m_l[3] ? 1'b0 : v[m_l[2:0]]) ^ m_l[6];
      md = (m_src[3:0] == 4'h0) ? m_con[0] : (m_src[3:0] == 4'h1) ? sy[5] :
           (m_src[3:0] < 4'h6) ? pwm[m_src[1:0] - 2'h2] : 1'b0;
      if (!m_con[7] || md == cur)
        nxt = md;
      else if (cur ? (m_h[5] && !(hp && !h)) : (m_l[5] && !(lp && !l)))
        nxt = cur;
      else
        nxt = md;
      // output follows the selection held before this edge
      e_out = m_con[7] & ((cur ? h : l) ^ m_con[4]);
      e_oe = m_con[7] & m_con[6];
      e_slew = m_con[5];
      e_msd = m_src[7];
      e_pd = (m_h[7] && !m_h[3] ? 8'h01 << m_h[2:0] : 8'h00)
           | (m_l[7] && !m_l[3] ? 8'h01 << m_l[2:0] : 8'h00);
      cur = nxt;
      hp = h;
      lp = l;
      sy = {sy[4], mp, sy[2], p2, sy[0], p1};
      if (cyc && stb && we && !m_ack && sel[0])
        case (adr)
          DSM_ADDR_CON:  m_con = dat[7:0] & 8'hF1;
          DSM_ADDR_SRC:  m_src = dat[7:0] & 8'h8F;
          DSM_ADDR_CARH: m_h = dat[7:0] & 8'hEF;
          DSM_ADDR_CARL: m_l = dat[7:0] & 8'hEF;
          default:       ;
        endcase
      m_ack = cyc && stb && !m_ack;
    end
  end

  // ----------------------------------------
  // comparison and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(negedge clk)
    if (run)
    begin
      check("out", 32'(out), 32'(e_out));
      check("pin_en", 32'(oe), 32'(e_oe));
      check("slew", 32'(slew), 32'(e_slew));
      check("pin_dis", {24'h0, pd}, {24'h0, e_pd});
      check("src_dis", 32'(msd), 32'(e_msd));
      check("ack", 32'(ack), 32'(m_ack));
    end

  // one classic cycle; holds until ack is sampled, then idles a cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      finish_test();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h28C1C888));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    por_n <= 1'b1;
    run <= 1'b1;
    @(posedge clk);
    wb(1'b1, 4'h6, 4'hF, 32'h0000_00FF);
    wb(1'b0, 4'h6, 4'hF, 32'h0);
    check("unmapped", rdat, 32'h0);
    // every selector code on both paths, random control bits and sources
    for (int i = 0; i < 48; i++)
    begin
      wb(1'b1, DSM_ADDR_CARH, (i == 5) ? 4'h0 : 4'hF, {24'h0, 4'($urandom), 4'(i)});
      wb(1'b1, DSM_ADDR_CARL, 4'hF, {24'h0, 4'($urandom), 4'(15 - i)});
      wb(1'b1, DSM_ADDR_SRC, 4'hF, {24'h0, 1'($urandom), 3'h7, 4'($urandom_range(0, 6))});
      wb(1'b1, DSM_ADDR_CON, 4'hF, {24'h0, 1'(i % 4 != 3), 7'($urandom)});
      wb(1'b0, DSM_ADDR_CARH, 4'hF, 32'h0);
      check("carh", rdat, {24'h0, m_h});
      wb(1'b0, DSM_ADDR_CARL, 4'hF, 32'h0);
      check("carl", rdat, {24'h0, m_l});
      wb(1'b0, DSM_ADDR_SRC, 4'hF, 32'h0);
      check("src", rdat, {24'h0, m_src});
      repeat (40) @(posedge clk);
    end
    // device reset in mid-run: carrier settings survive, modulator is off
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    wb(1'b0, DSM_ADDR_CARH, 4'hF, 32'h0);
    check("carh_kept", rdat, {24'h0, m_h});
    wb(1'b0, DSM_ADDR_CON, 4'hF, 32'h0);
    check("con_reset", rdat, 32'h0000_0020);
    repeat (20) @(posedge clk);
    finish_test();
  end
endmodule // tb_dsm_carrier_select
